//--- qev_core.sv
`timescale 1ns/1ps
`include "qev_params.svh"
module qev_core
	import qev_pkg::*;
(
	input  wire logic        SYS_CLK,
	input  wire logic        RST_N,
	input  wire logic        HSEL,
	input  wire logic [31:0] HADDR,
	input  wire logic [1:0]  HTRANS,
	input  wire logic        HWRITE,
	input  wire logic [2:0]  HSIZE,
	input  wire logic [31:0] HWDATA,
	input  wire logic        HREADY,
	output logic      [31:0] HRDATA,
	output logic             HREADYOUT,
	output logic             HRESP,
	input  wire logic        PHASE_A_INPUT,
	input  wire logic        PHASE_B_INPUT,
	input  wire logic        INDEX_INPUT,
	output logic             INT_IRQ
);

	qev_core_t              cur;       // Registered state
	qev_core_t              next_cur;  // Next state
	logic                   accept;    // Address phase taken
	logic                   enc_on;    // Encoder enabled
	logic                   vel_on;    // Velocity running
	logic                   div_pulse; // Predivided increment
	logic                   pos_wr;    // Position write now
	logic [7:0]             pdiv_mask; // Predivider terminal
	logic [2:0]             pdiv_exp;  // Predivider exponent
	logic [`QEV_INT_W-1:0]  int_set;   // Events this cycle
	logic [`QEV_INT_W-1:0]  int_clr;   // Clears this cycle
	logic [31:0]            rdata;     // Read mux

	qev_dec_if dec ();

	// ==========================================
	// Phase decoder
	qev_decoder u_dec (
		.clk   (SYS_CLK),
		.rst_n (RST_N),
		.pins  ({INDEX_INPUT, PHASE_B_INPUT, PHASE_A_INPUT}),
		.dec   (dec)
	);

	// Decoder configuration
	assign dec.clk_dir_mode = cur.ctrl[`QEV_CTRL_CLKDIR];
	assign dec.swap = cur.ctrl[`QEV_CTRL_SWAP];
	assign dec.both_edges = cur.ctrl[`QEV_CTRL_BOTH];

	// ==========================================
	// Main next-state logic
	always_comb begin
		next_cur = cur;
		int_set = '0;
		int_clr = '0;
		div_pulse = 1'b0;
		rdata = '0;
		enc_on = cur.ctrl[`QEV_CTRL_EN];
		vel_on = enc_on && cur.ctrl[`QEV_CTRL_VEN];
		pdiv_exp = cur.ctrl[`QEV_CTRL_PDIV_MSB:`QEV_CTRL_PDIV_LSB];
		pdiv_mask = 8'((9'h001 << pdiv_exp) - 9'h001);
		pos_wr = cur.wr_pend && cur.addr == `QEV_OFS_POS;
		accept = HSEL && HTRANS[`QEV_HTRANS_ACT_BIT] && HREADY;

		// Position counting with wrap at the limit
		if (enc_on && dec.step) begin
			if (dec.fwd) begin
				next_cur.pos = (cur.pos == cur.maxpos) ? '0 : cur.pos + 32'h00000001;
			end else begin
				next_cur.pos = (cur.pos == '0) ? cur.maxpos : cur.pos - 32'h00000001;
			end
			next_cur.dir = dec.fwd;
			// Direction change event
			int_set[`QEV_INT_DIR] = dec.fwd != cur.dir;
		end
		// Index reload only once an index arrives
		if (enc_on && dec.index_hit) begin
			int_set[`QEV_INT_IDX] = 1'b1;
			if (cur.ctrl[`QEV_CTRL_RIDX]) begin
				next_cur.pos = cur.dir ? '0 : cur.maxpos;
			end
		end
		// Phase error event
		int_set[`QEV_INT_ERR] = enc_on && dec.phase_err;

		// Velocity predivider and period timer
		if (!vel_on) begin
			next_cur.timer = '0;
			next_cur.acc = '0;
			next_cur.pre_cnt = '0;
		end else begin
			if (dec.step) begin
				if (cur.pre_cnt == pdiv_mask) begin
					div_pulse = 1'b1;
					next_cur.pre_cnt = '0;
				end else begin
					next_cur.pre_cnt = cur.pre_cnt + 8'h01;
				end
			end
			// Period end latches the total and restarts
			if (cur.timer >= cur.period - 32'h00000001) begin
				next_cur.vel = cur.acc + 32'(div_pulse);
				next_cur.acc = '0;
				next_cur.timer = '0;
				int_set[`QEV_INT_TMR] = 1'b1;
			end else begin
				next_cur.timer = cur.timer + 32'h00000001;
				next_cur.acc = cur.acc + 32'(div_pulse);
			end
		end

		// Write data phase
		if (cur.wr_pend) begin
			case (cur.addr)
				`QEV_OFS_CTRL: begin
					next_cur.ctrl = HWDATA[`QEV_CTRL_W-1:0];
				end
				`QEV_OFS_MAXPOS: begin
					next_cur.maxpos = HWDATA;
				end
				`QEV_OFS_POS: begin
					next_cur.pos = HWDATA;
				end
				`QEV_OFS_PERIOD: begin
					next_cur.period = HWDATA;
				end
				`QEV_OFS_INT_EN: begin
					next_cur.int_en = HWDATA[`QEV_INT_W-1:0];
				end
				`QEV_OFS_INT_CLR: begin
					int_clr = HWDATA[`QEV_INT_W-1:0];
				end
				default: begin
					// Unmapped or read-only, ignored
				end
			endcase
		end

		// Read mux
		case (cur.addr)
			`QEV_OFS_CTRL:       rdata = 32'(cur.ctrl);
			`QEV_OFS_MAXPOS:     rdata = cur.maxpos;
			`QEV_OFS_POS:        rdata = cur.pos;
			`QEV_OFS_PERIOD:     rdata = cur.period;
			`QEV_OFS_VEL:        rdata = cur.vel;
			`QEV_OFS_VELRUN:     rdata = cur.acc;
			`QEV_OFS_STATUS:     rdata = 32'({cur.int_raw[`QEV_INT_ERR], cur.dir});
			`QEV_OFS_INT_EN:     rdata = 32'(cur.int_en);
			`QEV_OFS_INT_RAW:    rdata = 32'(cur.int_raw);
			`QEV_OFS_INT_MASKED: rdata = 32'(cur.int_raw & cur.int_en);
			default:             rdata = '0;
		endcase

		// Read data phase, raw view read clears
		if (cur.rd_pend) begin
			next_cur.hrdata = rdata;
			next_cur.hreadyout = 1'b1;
			if (cur.addr == `QEV_OFS_INT_RAW) begin
				int_clr = int_clr | cur.int_raw;
			end
		end

		// Address phase
		next_cur.wr_pend = accept && HWRITE;
		next_cur.rd_pend = accept && !HWRITE;
		if (accept) begin
			next_cur.addr = HADDR[7:0];
			next_cur.hreadyout = HWRITE;
		end

		// Sticky flags, a new event beats a clear
		next_cur.int_raw = (cur.int_raw & ~int_clr) | int_set;
		// Response is always OKAY
		next_cur.hresp = 1'b0;
		// Interrupt follows the next flag state, no extra cycle of lag
		next_cur.irq = |(next_cur.int_raw & next_cur.int_en);
	end

	// State register
	always_ff @(posedge SYS_CLK or negedge RST_N) begin
		if (!RST_N) begin
			cur <= QEV_CORE_RST;
		end else begin
			cur <= next_cur;
		end
	end

	// Registered outputs
	assign HRDATA = cur.hrdata;
	assign HREADYOUT = cur.hreadyout;
	assign HRESP = cur.hresp;
	assign INT_IRQ = cur.irq;

	// ==========================================
	// Checks
	default clocking qev_cb @(posedge SYS_CLK);
	endclocking
	default disable iff (!RST_N);

	// Interrupt views and flags, position load and count, predivider and velocity capture
	AST_IRQ_ENABLED: assert property (
		INT_IRQ |-> |(cur.int_raw & cur.int_en))
		else $error("interrupt without enabled flag");
	AST_MASKED_VIEW: assert property (
		(cur.rd_pend && cur.addr == `QEV_OFS_INT_MASKED)
		|=> HRDATA == 32'($past(cur.int_raw & cur.int_en)) && HREADYOUT)
		else $error("masked view wrong");
	AST_POS_LOAD: assert property (
		pos_wr |=> cur.pos == $past(HWDATA))
		else $error("position load lost");
	AST_POS_COUNT: assert property (
		(enc_on && dec.step && dec.fwd && !dec.index_hit && !pos_wr && cur.pos != cur.maxpos)
		|=> cur.pos == $past(cur.pos) + 32'h00000001)
		else $error("position did not count up");
	AST_PREDIV: assert property (
		(vel_on && dec.step && cur.pre_cnt != pdiv_mask && !cur.wr_pend)
		|=> cur.pre_cnt == $past(cur.pre_cnt) + 8'h01)
		else $error("predivider did not advance");
	AST_VEL_LATCH: assert property (
		(vel_on && cur.timer >= cur.period - 32'h00000001)
		|=> cur.acc == '0 && cur.timer == '0 && cur.int_raw[`QEV_INT_TMR])
		else $error("period end not latched");
	AST_VEL_READ: assert property (
		(cur.rd_pend && cur.addr == `QEV_OFS_VEL) |=> HRDATA == $past(cur.vel))
		else $error("velocity read wrong");
	AST_VEL_OFF: assert property (
		!vel_on |=> cur.timer == '0 && cur.acc == '0)
		else $error("velocity ran while off");
	AST_ERR_FLAG: assert property (
		(enc_on && dec.phase_err) |=> cur.int_raw[`QEV_INT_ERR])
		else $error("phase error not flagged");
	AST_IDX_RELOAD: assert property (
		(enc_on && dec.index_hit && cur.ctrl[`QEV_CTRL_RIDX] && !pos_wr)
		|=> cur.pos == ($past(cur.dir) ? '0 : $past(cur.maxpos)))
		else $error("index reload wrong");
	AST_STICKY: assert property (
		(cur.int_raw[`QEV_INT_IDX] && !(cur.wr_pend && cur.addr == `QEV_OFS_INT_CLR)
		&& !(cur.rd_pend && cur.addr == `QEV_OFS_INT_RAW)) |=> cur.int_raw[`QEV_INT_IDX])
		else $error("flag dropped without clear");
	AST_CLR_W1C: assert property (
		(cur.wr_pend && cur.addr == `QEV_OFS_INT_CLR && HWDATA[`QEV_INT_IDX]
		&& !int_set[`QEV_INT_IDX]) |=> !cur.int_raw[`QEV_INT_IDX])
		else $error("write one did not clear flag");
	AST_DIR_FLAG: assert property (
		(enc_on && dec.step && dec.fwd != cur.dir) |=> cur.int_raw[`QEV_INT_DIR])
		else $error("direction change not flagged");
	AST_IDX_FLAG: assert property (
		(enc_on && dec.index_hit) |=> cur.int_raw[`QEV_INT_IDX])
		else $error("index not flagged");

	// Bus timing
	AST_RD_WAIT: assert property (
		(accept && !HWRITE) |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state wrong");
	AST_WR_NOWAIT: assert property (
		(accept && HWRITE) |=> HREADYOUT)
		else $error("write stalled the bus");

	// Position
	AST_POS_DOWN: assert property (
		(enc_on && dec.step && !dec.fwd && !dec.index_hit && !pos_wr && cur.pos != '0)
		|=> cur.pos == $past(cur.pos) - 32'h00000001)
		else $error("position did not count down");
	AST_POS_WRAP: assert property (
		(enc_on && dec.step && !dec.fwd && !dec.index_hit && !pos_wr && cur.pos == '0)
		|=> cur.pos == $past(cur.maxpos))
		else $error("position did not wrap to limit");
	AST_ENC_OFF: assert property (
		(!enc_on && !pos_wr) |=> cur.pos == $past(cur.pos))
		else $error("position moved while encoder off");
	AST_POS_VEL_OFF: assert property (
		(enc_on && !cur.ctrl[`QEV_CTRL_VEN] && dec.step && !dec.index_hit && !pos_wr
		&& cur.maxpos != '0) |=> cur.pos != $past(cur.pos))
		else $error("position stalled with velocity off");
	AST_IDX_NO_RELOAD: assert property (
		(enc_on && dec.index_hit && !cur.ctrl[`QEV_CTRL_RIDX] && !dec.step && !pos_wr)
		|=> cur.pos == $past(cur.pos))
		else $error("index reloaded outside index mode");

	// Velocity
	AST_PREDIV_WRAP: assert property (
		(vel_on && dec.step && cur.pre_cnt == pdiv_mask) |=> cur.pre_cnt == '0)
		else $error("predivider did not wrap");
	AST_TMR_COUNT: assert property (
		(vel_on && cur.timer < cur.period - 32'h00000001)
		|=> cur.timer == $past(cur.timer) + 32'h00000001)
		else $error("period timer did not advance");
	AST_ACC_COUNT: assert property (
		(vel_on && cur.timer < cur.period - 32'h00000001 && div_pulse)
		|=> cur.acc == $past(cur.acc) + 32'h00000001)
		else $error("accumulator missed a pulse");
	AST_VEL_HOLD: assert property (
		!(vel_on && cur.timer >= cur.period - 32'h00000001) |=> cur.vel == $past(cur.vel))
		else $error("velocity result changed mid period");

	// Main scenarios
	COV_WRAP: cover property (enc_on && dec.step && dec.fwd && cur.pos == cur.maxpos);
	COV_LATCH: cover property (vel_on && cur.timer >= cur.period - 32'h00000001 && cur.acc != '0);
	COV_IRQ: cover property (!INT_IRQ ##1 INT_IRQ);
	COV_INDEX: cover property (enc_on && dec.index_hit && cur.ctrl[`QEV_CTRL_RIDX]);
	COV_RD_CLEAR: cover property (cur.rd_pend && cur.addr == `QEV_OFS_INT_RAW && cur.int_raw != '0);

endmodule

//--- qev_dec_if.sv
`timescale 1ns/1ps
// ==========================================
// Decoder to core carrier
interface qev_dec_if;
	logic clk_dir_mode;  // Clock and direction inputs
	logic swap;          // Swap phases before decode
	logic both_edges;    // Count both phase edges
	logic step;          // Increment pulse
	logic fwd;           // Increment direction
	logic phase_err;     // Phase error pulse
	logic index_hit;     // Index pulse
	modport decoder (input clk_dir_mode, swap, both_edges, output step, fwd, phase_err, index_hit);
	modport core (output clk_dir_mode, swap, both_edges, input step, fwd, phase_err, index_hit);
endinterface

//--- qev_decoder.sv
`timescale 1ns/1ps
`include "qev_params.svh"
module qev_decoder
	import qev_pkg::*;
(
	input  wire logic clk,
	input  wire logic rst_n,
	input  wire logic [2:0] pins,
	qev_dec_if.decoder dec
);

	qev_dec_t cur;       // Registered state
	qev_dec_t next_cur;  // Next state
	logic     a;         // Current phase A after swap
	logic     b;         // Current phase B after swap
	logic     pa;        // Previous phase A
	logic     pb;        // Previous phase B
	logic     da;        // Phase A changed
	logic     db;        // Phase B changed

	// ==========================================
	// Sampling and decode
	always_comb begin
		next_cur = cur;
		next_cur.sync1 = pins;
		next_cur.sync2 = cur.sync1;
		next_cur.prev = cur.sync2;
		// Optional swap of the phases
		a = dec.swap ? cur.sync2[`QEV_PIN_B] : cur.sync2[`QEV_PIN_A];
		b = dec.swap ? cur.sync2[`QEV_PIN_A] : cur.sync2[`QEV_PIN_B];
		pa = dec.swap ? cur.prev[`QEV_PIN_B] : cur.prev[`QEV_PIN_A];
		pb = dec.swap ? cur.prev[`QEV_PIN_A] : cur.prev[`QEV_PIN_B];
		da = a ^ pa;
		db = b ^ pb;
		next_cur.step = 1'b0;
		next_cur.err = 1'b0;
		if (dec.clk_dir_mode) begin
			// Rising clock counts, high direction is reverse
			if (a && !pa) begin
				next_cur.step = 1'b1;
				next_cur.fwd = !b;
			end
		end else begin
			// Both phases at once is an error
			next_cur.err = da && db;
			if ((da && !db) || (db && !da && dec.both_edges)) begin
				next_cur.step = 1'b1;
				next_cur.fwd = da ? (a ^ b) : !(a ^ b);
			end
		end
		// Index rising edge
		next_cur.idx = cur.sync2[`QEV_PIN_IDX] && !cur.prev[`QEV_PIN_IDX];
	end

	// State register
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// Outputs to the core
	assign dec.step = cur.step;
	assign dec.fwd = cur.fwd;
	assign dec.phase_err = cur.err;
	assign dec.index_hit = cur.idx;

	// ==========================================
	// Checks
	AST_CLKDIR_STEP: assert property (@(posedge clk) disable iff (!rst_n)
		(dec.clk_dir_mode && !dec.swap && cur.sync2[`QEV_PIN_A] && !cur.prev[`QEV_PIN_A])
		|=> (cur.step && cur.fwd == !$past(cur.sync2[`QEV_PIN_B])))
		else $error("clock mode edge did not step");

endmodule

//--- qev_enc_model.sv
`timescale 1ns/1ps
// ==========================================
// Encoder model: two phases and an index pin
module qev_enc_model
	import qev_pkg::*;
(
	input  wire logic clk,     // Bench clock
	input  wire logic rst_n,   // Reset, active low
	input  wire logic step,    // One step request
	input  wire logic fwd,     // Step direction
	input  wire logic err,     // Flip both phases at once, quadrature output only
	input  wire logic idx,     // Index pulse request
	input  wire logic cd_mode, // Clock and direction output
	output logic      pa,      // Phase A pin
	output logic      pb,      // Phase B pin
	output logic      pi       // Index pin
);
	logic [1:0] s;  // Gray position
	logic [1:0] ic; // Index high time left

	// Gray stepping; a bad double flip only on request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s  <= 2'h0;
			ic <= 2'h0;
		end else begin
			if (err) begin
				s <= s + 2'h2;
			end else if (step) begin
				s <= fwd ? s + 2'h1 : s - 2'h1;
			end
			if (idx) begin
				ic <= 2'h3;
			end else if (ic != 2'h0) begin
				ic <= ic - 2'h1;
			end
		end
	end

	// A leads B going forward; else clock on A and reverse level on B
	assign pa = cd_mode ? s[0] : s[0] ^ s[1];
	assign pb = cd_mode ? ~fwd : s[1];
	assign pi = (ic != 2'h0);
endmodule

//--- qev_params.svh
// Functional notes
// - Each interrupt source has its own enable
// - Raw and masked interrupt views readable
// - Position readable, writable, counting continues from it
// - Index mode unaligned until first index
// - Increments predivided by 1 to 128
// - Accumulate over period, latch, then clear
// - Velocity needs velocity and encoder enable
// - Velocity read returns last completed period
// - Velocity off leaves position decoding running
// - Quadrature or clock/direction input, optional swap
// - Both phases changing flags phase error in quadrature mode
// - Index reloads zero forward, maximum reverse
// - Flags for index, timer, direction, error
`ifndef QEV_PARAMS_SVH
`define QEV_PARAMS_SVH

// ==========================================
// Register offsets
`define QEV_OFS_CTRL       8'h00
`define QEV_OFS_MAXPOS     8'h04
`define QEV_OFS_POS        8'h08
`define QEV_OFS_PERIOD     8'h0C
`define QEV_OFS_VEL        8'h10
`define QEV_OFS_VELRUN     8'h14
`define QEV_OFS_STATUS     8'h18
`define QEV_OFS_INT_EN     8'h1C
`define QEV_OFS_INT_RAW    8'h20
`define QEV_OFS_INT_MASKED 8'h24
`define QEV_OFS_INT_CLR    8'h28

// ==========================================
// Control register fields
`define QEV_CTRL_W         9
`define QEV_CTRL_EN        0
`define QEV_CTRL_CLKDIR    1
`define QEV_CTRL_SWAP      2
`define QEV_CTRL_BOTH      3
`define QEV_CTRL_RIDX      4
`define QEV_CTRL_VEN       5
`define QEV_CTRL_PDIV_LSB  6
`define QEV_CTRL_PDIV_MSB  8

// ==========================================
// Status and interrupt fields
`define QEV_STAT_DIR       0
`define QEV_STAT_ERR       1
`define QEV_INT_W          4
`define QEV_INT_ERR        0
`define QEV_INT_DIR        1
`define QEV_INT_TMR        2
`define QEV_INT_IDX        3

// ==========================================
// Reset values and bus constants
`define QEV_RST_MAXPOS     32'hFFFFFFFF
`define QEV_RST_PERIOD     32'h00000001
`define QEV_HTRANS_ACT_BIT 1
`define QEV_PIN_A          0
`define QEV_PIN_B          1
`define QEV_PIN_IDX        2

`endif

//--- qev_pkg.sv
`include "qev_params.svh"
package qev_pkg;

	// ==========================================
	// Decoder state
	typedef struct packed {
		logic [2:0] sync1;     // First synchroniser stage
		logic [2:0] sync2;     // Second synchroniser stage
		logic [2:0] prev;      // Previous settled sample
		logic       step;      // One position increment
		logic       fwd;       // Direction of last increment
		logic       err;       // Both phases moved together
		logic       idx;       // Index rising edge
	} qev_dec_t;

	// ==========================================
	// Core state
	typedef struct packed {
		logic [31:0]              hrdata;     // Read data
		logic                     hreadyout;  // Bus ready
		logic                     hresp;      // Always OKAY
		logic                     irq;        // Interrupt line
		logic                     rd_pend;    // Read data phase
		logic                     wr_pend;    // Write data phase
		logic [7:0]               addr;       // Latched offset
		logic [`QEV_CTRL_W-1:0]   ctrl;       // Control bits
		logic [31:0]              maxpos;     // Position limit
		logic [31:0]              pos;        // Position count
		logic [31:0]              period;     // Velocity period
		logic [31:0]              vel;        // Latched velocity
		logic [31:0]              acc;        // Running velocity
		logic [31:0]              timer;      // Period tick count
		logic [7:0]               pre_cnt;    // Predivider count
		logic [`QEV_INT_W-1:0]    int_raw;    // Sticky flags
		logic [`QEV_INT_W-1:0]    int_en;     // Flag enables
		logic                     dir;        // 1 forward
	} qev_core_t;

	// Core reset value
	localparam qev_core_t QEV_CORE_RST = '{
		hreadyout: 1'b1,
		maxpos:    `QEV_RST_MAXPOS,
		period:    `QEV_RST_PERIOD,
		dir:       1'b1,
		default:   '0
	};

endpackage

//--- tb_quadrature_encoder_velocity.sv
`timescale 1ns/1ps
`include "qev_params.svh"
module tb_quadrature_encoder_velocity
	import qev_pkg::*;
;
	logic        SYS_CLK;   // Bench clock
	logic        RST_N;     // Reset, active low
	logic        HSEL;      // Slave select
	logic        HWRITE;    // Write transfer
	logic [1:0]  HTRANS;    // Transfer kind
	logic [31:0] HADDR;     // Byte address
	logic [31:0] HWDATA;    // Write data
	logic [31:0] HRDATA;    // Read data
	logic        HREADYOUT; // Slave ready, also bus ready
	logic        HRESP;     // Response
	logic        INT_IRQ;   // Interrupt line
	logic        pa, pb, pi;                  // Encoder pins
	logic        m_step, m_fwd, m_err, m_idx; // Model requests
	logic        m_cd;                        // Model output mode
	logic        run, bg_step;                // Background stepper
	logic [2:0]  sc;                          // Stepper phase
	logic [31:0] rd;                          // Last read data
	int          errors, n_checks;

	// Table row: setup, steps and expected position
	typedef struct packed {
		logic [8:0]  ctrl;
		logic        cd;
		logic        fwd;
		logic [3:0]  n;
		logic [31:0] start;
		logic [31:0] exp;
	} qev_row_t;
	localparam qev_row_t ROWS [7] = '{
		'{9'h009, 1'b0, 1'b1, 4'h5, 32'h0, 32'h5},
		'{9'h009, 1'b0, 1'b0, 4'h3, 32'hA, 32'h7},
		'{9'h00D, 1'b0, 1'b1, 4'h4, 32'hA, 32'h6},
		'{9'h009, 1'b0, 1'b0, 4'h1, 32'h0, 32'hFFFFFFFF},
		'{9'h001, 1'b0, 1'b1, 4'h4, 32'h10, 32'h12},
		'{9'h003, 1'b1, 1'b1, 4'h4, 32'h64, 32'h66},
		'{9'h003, 1'b1, 1'b0, 4'h4, 32'h64, 32'h62}
	};

	// ==========================================
	// Clock, design and encoder
	initial begin
		SYS_CLK = 1'b0;
		forever #25 SYS_CLK = ~SYS_CLK;
	end

	qev_core i_qev_core (.SYS_CLK(SYS_CLK), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR),
		.HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(3'h2), .HWDATA(HWDATA),
		.HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
		.PHASE_A_INPUT(pa), .PHASE_B_INPUT(pb), .INDEX_INPUT(pi), .INT_IRQ(INT_IRQ));

	qev_enc_model i_qev_enc_model (.clk(SYS_CLK), .rst_n(RST_N), .step(m_step | bg_step),
		.fwd(m_fwd), .err(m_err), .idx(m_idx), .cd_mode(m_cd), .pa(pa), .pb(pb), .pi(pi));

	// One step every eight cycles while running
	always @(posedge SYS_CLK) begin
		if (!run) begin
			sc      <= 3'h0;
			bg_step <= 1'b0;
		end else begin
			sc      <= sc + 3'h1;
			bg_step <= (sc == 3'h0);
		end
	end

	// ==========================================
	// Tasks
	task automatic conclude;
		$display("checks %0d, errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask

	// Wait for ready, judged where it settles before the next edge
	task automatic wait_rdy;
		int k;
		k = 0;
		@(negedge SYS_CLK);
		while (HREADYOUT !== 1'b1) begin
			k++;
			if (k > 20) begin
				errors++;
				conclude();
			end
			@(negedge SYS_CLK);
		end
	endtask

	// One single AHB-Lite word transfer, entered just after a rising edge
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
		HSEL   <= 1'b1;
		HTRANS <= 2'h2;
		HADDR  <= {24'h0, a};
		HWRITE <= wr;
		wait_rdy();
		@(posedge SYS_CLK);
		HSEL   <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= wd;
		wait_rdy();
		rd = HRDATA;
		chk({31'h0, HRESP}, 32'h0);
		@(posedge SYS_CLK);
	endtask

	task automatic w(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask

	task automatic r(input logic [7:0] a, input logic [31:0] e);
		xfer(1'b0, a, 32'h0);
		chk(rd, e);
	endtask

	task automatic irq_is(input logic e);
		@(negedge SYS_CLK);
		chk({31'h0, INT_IRQ}, {31'h0, e});
		@(posedge SYS_CLK);
	endtask

	// Encoder action: 0 step, 1 double flip, 2 index
	task automatic act(input int kind, input int n);
		for (int i = 0; i < n; i++) begin
			case (kind)
				0: m_step <= 1'b1;
				1: m_err <= 1'b1;
				default: m_idx <= 1'b1;
			endcase
			@(posedge SYS_CLK);
			m_step <= 1'b0;
			m_err  <= 1'b0;
			m_idx  <= 1'b0;
			repeat (7) @(posedge SYS_CLK);
		end
	endtask

	// ==========================================
	// Main sequence
	initial begin
		{RST_N, HSEL, HWRITE, HTRANS, HADDR, HWDATA} = '0;
		{m_step, m_err, m_idx, m_cd, run} = '0;
		m_fwd    = 1'b1;
		errors   = 0;
		n_checks = 0;
		repeat (5) @(posedge SYS_CLK);
		RST_N <= 1'b1;
		@(posedge SYS_CLK);
		r(`QEV_OFS_CTRL, 32'h0);
		r(`QEV_OFS_MAXPOS, `QEV_RST_MAXPOS);
		r(`QEV_OFS_POS, 32'h0);
		r(`QEV_OFS_PERIOD, `QEV_RST_PERIOD);
		r(`QEV_OFS_INT_EN, 32'h0);
		w(8'h3C, 32'hFFFFFFFF);
		r(8'h3C, 32'h0);
		w(`QEV_OFS_VEL, 32'h55);
		r(`QEV_OFS_VEL, 32'h0);
		foreach (ROWS[i]) begin
			w(`QEV_OFS_CTRL, 32'h0);
			m_cd  <= ROWS[i].cd;
			m_fwd <= ROWS[i].fwd;
			repeat (8) @(posedge SYS_CLK);
			w(`QEV_OFS_POS, ROWS[i].start);
			w(`QEV_OFS_CTRL, {23'h0, ROWS[i].ctrl});
			act(0, ROWS[i].n);
			r(`QEV_OFS_POS, ROWS[i].exp);
		end
		// Masking, raw and masked views, both clear paths
		w(`QEV_OFS_CTRL, 32'h0);
		m_cd <= 1'b0;
		repeat (8) @(posedge SYS_CLK);
		w(`QEV_OFS_CTRL, 32'h9);
		w(`QEV_OFS_INT_CLR, 32'hF);
		act(1, 1);
		r(`QEV_OFS_INT_MASKED, 32'h0);
		r(`QEV_OFS_STATUS, 32'h2);
		irq_is(1'b0);
		w(`QEV_OFS_INT_EN, 32'h1);
		irq_is(1'b1);
		r(`QEV_OFS_INT_MASKED, 32'h1);
		r(`QEV_OFS_INT_RAW, 32'h1);
		irq_is(1'b0);
		act(1, 1);
		w(`QEV_OFS_INT_CLR, 32'h1);
		r(`QEV_OFS_INT_RAW, 32'h0);
		m_fwd <= 1'b1;
		act(0, 1);
		w(`QEV_OFS_INT_CLR, 32'hF);
		m_fwd <= 1'b0;
		act(0, 1);
		r(`QEV_OFS_INT_RAW, 32'h2);
		// Reset on index, both directions
		w(`QEV_OFS_MAXPOS, 32'h3E7);
		w(`QEV_OFS_POS, 32'h32);
		w(`QEV_OFS_CTRL, 32'h19);
		w(`QEV_OFS_INT_EN, 32'h8);
		m_fwd <= 1'b1;
		act(0, 2);
		r(`QEV_OFS_POS, 32'h34);
		act(2, 1);
		r(`QEV_OFS_POS, 32'h0);
		r(`QEV_OFS_INT_MASKED, 32'h8);
		m_fwd <= 1'b0;
		act(0, 3);
		r(`QEV_OFS_POS, 32'h3E5);
		act(2, 1);
		r(`QEV_OFS_POS, 32'h3E7);
		// Velocity: 128 steps in each 1024-tick period, every predivider
		m_fwd <= 1'b1;
		w(`QEV_OFS_CTRL, 32'h9);
		w(`QEV_OFS_PERIOD, 32'h400);
		run <= 1'b1;
		for (int n = 0; n < 8; n++) begin
			w(`QEV_OFS_CTRL, {23'h0, 3'(n), 6'h09});
			w(`QEV_OFS_CTRL, {23'h0, 3'(n), 6'h29});
			repeat (2100) @(posedge SYS_CLK);
			r(`QEV_OFS_VEL, 32'h80 >> n);
		end
		w(`QEV_OFS_INT_CLR, 32'hF);
		repeat (1100) @(posedge SYS_CLK);
		r(`QEV_OFS_INT_RAW, 32'h4);
		// Encoder off: no capture even with velocity on
		w(`QEV_OFS_CTRL, 32'h1E0);
		w(`QEV_OFS_INT_CLR, 32'hF);
		repeat (2100) @(posedge SYS_CLK);
		r(`QEV_OFS_VEL, 32'h1);
		r(`QEV_OFS_INT_RAW, 32'h0);
		r(`QEV_OFS_VELRUN, 32'h0);
		run <= 1'b0;
		// Let a last background step drain before the encoder comes back on
		repeat (8) @(posedge SYS_CLK);
		// Velocity off, position still counts
		w(`QEV_OFS_CTRL, 32'h9);
		w(`QEV_OFS_POS, 32'h0);
		act(0, 4);
		r(`QEV_OFS_POS, 32'h4);
		r(`QEV_OFS_VEL, 32'h1);
		conclude();
	end

	// Whole-run guard
	initial begin
		repeat (60000) @(posedge SYS_CLK);
		errors++;
		conclude();
	end
endmodule
